// >>> hdl/bad_datapath.sv
// Byte ALU datapath: one-cycle byte operations, two-cycle word operations
// Operation
// RL1: Add registers, optionally plus carry; update Z,C,N,V,H in one cycle.
// RL2: Word add of immediate to register pair; Z,C,N,V,S; two cycles.
// RL3: Subtract register or constant from target; Z,C,N,V,H in one cycle.
// RL4: Subtract register and carry from target; Z,C,N,V,H; one cycle.
// RL5: Subtract constant and carry from target; five arithmetic flags; one cycle.
// RL6: Word subtract of immediate from register pair; Z,C,N,V,S; two cycles.
// RL7: AND with register or constant; Z,N,V; one cycle.
// RL8: OR with register or constant; Z,N,V; one cycle.
// RL9: Set bits given by mask in target; one cycle.
// RL10: Clear bits: AND with 0xFF minus mask; Z,N,V; one cycle.
// RL11: Test: AND target with itself, value unchanged, Z,N,V updated.
// RL12: XOR, invert, negate, increment, decrement in one cycle with their flags.
// RL13: Word pair: low byte in named register, high in next; carry low to high.
module bad_datapath
    import bad_pkg::*;
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    // Decoder request
    input  wire logic       i_req_valid,
    input  wire bad_req_t   i_req,
    // Register file write and status
    output bad_wr_t         o_wr,
    output bad_flags_t      o_flags,
    output logic            o_busy,
    output logic            o_done
);

    bad_state_t state_reg, state_next;
    bad_wr_t    wr_reg, wr_next;
    bad_flags_t flags_reg, flags_next;
    logic       busy_reg, busy_next;
    logic       done_reg, done_next;
    logic [7:0] word_hi_reg, word_hi_next;
    logic [4:0] word_idx_reg, word_idx_next;
    logic       word_c_reg, word_c_next;
    logic       word_sub_reg, word_sub_next;
    logic       word_lo_zero_reg, word_lo_zero_next;

    logic [7:0] add_a;
    logic [7:0] add_b;
    logic       add_cin;
    logic       add_sub;
    logic [7:0] sum;
    logic       sum_c;
    logic       sum_h;
    logic       sum_v;

    // Flags of logic results: overflow cleared, carry and half-carry kept
    function automatic bad_flags_t logic_flags(input bad_flags_t old, input logic [7:0] res);
        bad_flags_t f;
        f   = old;
        f.v = 1'b0;
        f.n = res[7];
        f.z = (res == BAD_BYTE_ZERO);
        f.s = res[7];
        return f;
    endfunction

    // Flags of byte arithmetic results
    function automatic bad_flags_t arith_flags(input logic [7:0] res, input logic c, input logic h,
                                               input logic v);
        bad_flags_t f;
        f.c = c;
        f.h = h;
        f.v = v;
        f.n = res[7];
        f.z = (res == BAD_BYTE_ZERO);
        f.s = res[7] ^ v;
        return f;
    endfunction

    bad_adder8 u_adder (
        .i_a     (add_a),
        .i_b     (add_b),
        .i_cin   (add_cin),
        .i_sub   (add_sub),
        .o_res   (sum),
        .o_carry (sum_c),
        .o_half  (sum_h),
        .o_ovf   (sum_v)
    );

    // Adder operand selection
    always_comb
    begin
        add_a   = i_req.dst_val;
        add_b   = i_req.src_val;
        add_cin = 1'b0;
        add_sub = 1'b0;
        case (state_reg)
            BAD_ST_WORD_HI:
            begin
                // RL13 high byte takes low carry
                add_a   = word_hi_reg;
                add_b   = BAD_BYTE_ZERO;
                add_cin = word_c_reg;
                add_sub = word_sub_reg;
            end
            BAD_ST_IDLE:
            begin
                case (i_req.op)
                    BAD_OP_ADD_WITH_CARRY:
                    begin
                        // RL1 carry included
                        add_cin = flags_reg.c;
                    end
                    BAD_OP_MINUS_REGISTER, BAD_OP_MINUS_CONSTANT, BAD_OP_WORD_IMMEDIATE_DECREASE:
                    begin
                        add_sub = 1'b1;
                    end
                    BAD_OP_MINUS_WITH_BORROW, BAD_OP_MINUS_CONST_WITH_BORROW:
                    begin
                        // RL4 RL5 borrow subtracted
                        add_sub = 1'b1;
                        add_cin = flags_reg.c;
                    end
                    BAD_OP_ARITHMETIC_MINUS_SELF:
                    begin
                        add_a   = BAD_BYTE_ZERO;
                        add_b   = i_req.dst_val;
                        add_sub = 1'b1;
                    end
                    BAD_OP_PLUS_ONE:
                    begin
                        add_b = BAD_BYTE_ONE;
                    end
                    BAD_OP_MINUS_ONE:
                    begin
                        add_b   = BAD_BYTE_ONE;
                        add_sub = 1'b1;
                    end
                    default:
                    begin
                        add_sub = 1'b0;
                    end
                endcase
            end
            default:
            begin
                add_sub = 1'b0;
            end
        endcase
    end

    // Next-state and result computation
    always_comb
    begin
        state_next        = state_reg;
        wr_next           = wr_reg;
        wr_next.en        = 1'b0;
        flags_next        = flags_reg;
        busy_next         = 1'b0;
        done_next         = 1'b0;
        word_hi_next      = word_hi_reg;
        word_idx_next     = word_idx_reg;
        word_c_next       = word_c_reg;
        word_sub_next     = word_sub_reg;
        word_lo_zero_next = word_lo_zero_reg;
        case (state_reg)
            BAD_ST_IDLE:
            begin
                if (i_req_valid && (i_req.op != BAD_OP_NOP))
                begin
                    wr_next.en  = 1'b1;
                    wr_next.idx = i_req.dst_idx;
                    wr_next.data = sum;
                    done_next   = 1'b1;
                    case (i_req.op)
                        BAD_OP_ADD_REGISTERS, BAD_OP_ADD_WITH_CARRY, BAD_OP_MINUS_REGISTER,
                        BAD_OP_MINUS_CONSTANT, BAD_OP_ARITHMETIC_MINUS_SELF:
                        begin
                            // RL1 RL3 RL12 full byte arithmetic flags
                            flags_next = arith_flags(sum, sum_c, sum_h, sum_v);
                        end
                        BAD_OP_MINUS_WITH_BORROW, BAD_OP_MINUS_CONST_WITH_BORROW:
                        begin
                            // RL4 RL5 zero sticks across chained bytes
                            flags_next   = arith_flags(sum, sum_c, sum_h, sum_v);
                            flags_next.z = (sum == BAD_BYTE_ZERO) && flags_reg.z;
                        end
                        BAD_OP_PLUS_ONE, BAD_OP_MINUS_ONE:
                        begin
                            // RL12 carry untouched for counting loops
                            flags_next   = arith_flags(sum, flags_reg.c, flags_reg.h, sum_v);
                        end
                        BAD_OP_WORD_IMMEDIATE_INCREASE, BAD_OP_WORD_IMMEDIATE_DECREASE:
                        begin
                            // RL2 RL6 low byte first, flags after high byte
                            done_next         = 1'b0;
                            busy_next         = 1'b1;
                            state_next        = BAD_ST_WORD_HI;
                            word_hi_next      = i_req.hi_val;
                            word_idx_next     = i_req.dst_idx + BAD_PAIR_STEP;
                            word_c_next       = sum_c;
                            word_sub_next     = add_sub;
                            word_lo_zero_next = (sum == BAD_BYTE_ZERO);
                        end
                        BAD_OP_AND_REGISTERS, BAD_OP_MASK_WITH_CONSTANT:
                        begin
                            // RL7 conjunction
                            wr_next.data = i_req.dst_val & i_req.src_val;
                            flags_next   = logic_flags(flags_reg, wr_next.data);
                        end
                        BAD_OP_OR_REGISTERS, BAD_OP_MERGE_WITH_CONSTANT, BAD_OP_SET_MASK_BITS:
                        begin
                            // RL8 RL9 disjunction forces mask bits
                            wr_next.data = i_req.dst_val | i_req.src_val;
                            flags_next   = logic_flags(flags_reg, wr_next.data);
                        end
                        BAD_OP_CLEAR_MASK_BITS:
                        begin
                            // RL10 and with inverted mask
                            wr_next.data = i_req.dst_val & (BAD_BYTE_ONES - i_req.src_val);
                            flags_next   = logic_flags(flags_reg, wr_next.data);
                        end
                        BAD_OP_EXCLUSIVE_OR_REGISTERS:
                        begin
                            // RL12 exclusive or
                            wr_next.data = i_req.dst_val ^ i_req.src_val;
                            flags_next   = logic_flags(flags_reg, wr_next.data);
                        end
                        BAD_OP_BITWISE_INVERT:
                        begin
                            // RL12 complement sets carry
                            wr_next.data = BAD_BYTE_ONES - i_req.dst_val;
                            flags_next   = logic_flags(flags_reg, wr_next.data);
                            flags_next.c = 1'b1;
                        end
                        BAD_OP_ZERO_SIGN_CHECK:
                        begin
                            // RL11 no write, flags only; last write stays on the bus
                            wr_next      = '{en: 1'b0, idx: wr_reg.idx, data: wr_reg.data};
                            flags_next   = logic_flags(flags_reg, i_req.dst_val & i_req.dst_val);
                        end
                        default:
                        begin
                            wr_next    = '{en: 1'b0, idx: wr_reg.idx, data: wr_reg.data};
                            done_next  = 1'b0;
                        end
                    endcase
                end
            end
            BAD_ST_WORD_HI:
            begin
                // RL13 high byte to next register
                wr_next.en   = 1'b1;
                wr_next.idx  = word_idx_reg;
                wr_next.data = sum;
                // RL2 RL6 word flags from 16-bit result
                flags_next.c = sum_c;
                flags_next.v = sum_v;
                flags_next.n = sum[7];
                flags_next.s = sum[7] ^ sum_v;
                flags_next.z = word_lo_zero_reg && (sum == BAD_BYTE_ZERO);
                done_next    = 1'b1;
                state_next   = BAD_ST_IDLE;
            end
            default:
            begin
                state_next = BAD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            state_reg        <= BAD_ST_IDLE;
            wr_reg           <= BAD_WR_RESET;
            flags_reg        <= BAD_FLAGS_RESET;
            busy_reg         <= 1'b0;
            done_reg         <= 1'b0;
            word_hi_reg      <= BAD_BYTE_ZERO;
            word_idx_reg     <= BAD_IDX_RESET;
            word_c_reg       <= 1'b0;
            word_sub_reg     <= 1'b0;
            word_lo_zero_reg <= 1'b0;
        end
        else
        begin
            state_reg        <= state_next;
            wr_reg           <= wr_next;
            flags_reg        <= flags_next;
            busy_reg         <= busy_next;
            done_reg         <= done_next;
            word_hi_reg      <= word_hi_next;
            word_idx_reg     <= word_idx_next;
            word_c_reg       <= word_c_next;
            word_sub_reg     <= word_sub_next;
            word_lo_zero_reg <= word_lo_zero_next;
        end
    end

    assign o_wr    = wr_reg;
    assign o_flags = flags_reg;
    assign o_busy  = busy_reg;
    assign o_done  = done_reg;

endmodule // bad_datapath

// >>> hdl/bad_pkg.sv
// Shared types and constants for the byte ALU datapath
package bad_pkg;

    localparam int unsigned BAD_DATA_W  = 8;
    localparam int unsigned BAD_IDX_W   = 5;

    localparam logic [7:0] BAD_BYTE_ZERO   = 8'h00;
    localparam logic [7:0] BAD_BYTE_ONES   = 8'hFF;
    localparam logic [7:0] BAD_BYTE_ONE    = 8'h01;
    localparam logic [4:0] BAD_PAIR_STEP   = 5'h01;
    localparam logic [4:0] BAD_IDX_RESET   = 5'h00;

    // Operation codes issued by the instruction decoder
    typedef enum logic [4:0] {
        BAD_OP_NOP                     = 5'h00,
        BAD_OP_ADD_REGISTERS           = 5'h01,
        BAD_OP_ADD_WITH_CARRY          = 5'h02,
        BAD_OP_WORD_IMMEDIATE_INCREASE = 5'h03,
        BAD_OP_MINUS_REGISTER          = 5'h04,
        BAD_OP_MINUS_CONSTANT          = 5'h05,
        BAD_OP_MINUS_WITH_BORROW       = 5'h06,
        BAD_OP_MINUS_CONST_WITH_BORROW = 5'h07,
        BAD_OP_WORD_IMMEDIATE_DECREASE = 5'h08,
        BAD_OP_AND_REGISTERS           = 5'h09,
        BAD_OP_MASK_WITH_CONSTANT      = 5'h0A,
        BAD_OP_OR_REGISTERS            = 5'h0B,
        BAD_OP_MERGE_WITH_CONSTANT     = 5'h0C,
        BAD_OP_EXCLUSIVE_OR_REGISTERS  = 5'h0D,
        BAD_OP_BITWISE_INVERT          = 5'h0E,
        BAD_OP_ARITHMETIC_MINUS_SELF   = 5'h0F,
        BAD_OP_SET_MASK_BITS           = 5'h10,
        BAD_OP_CLEAR_MASK_BITS         = 5'h11,
        BAD_OP_PLUS_ONE                = 5'h12,
        BAD_OP_MINUS_ONE               = 5'h13,
        BAD_OP_ZERO_SIGN_CHECK         = 5'h14
    } bad_op_t;

    // Request from the decoder, operands already read from the register file
    typedef struct packed {
        bad_op_t        op;
        logic [4:0]     dst_idx;
        logic [7:0]     dst_val;
        logic [7:0]     src_val;
        logic [7:0]     hi_val;
    } bad_req_t;

    // Register file write port
    typedef struct packed {
        logic           en;
        logic [4:0]     idx;
        logic [7:0]     data;
    } bad_wr_t;

    // Status flags kept by the datapath
    typedef struct packed {
        logic           h;
        logic           s;
        logic           v;
        logic           n;
        logic           z;
        logic           c;
    } bad_flags_t;

    localparam bad_flags_t BAD_FLAGS_RESET = '{h: 1'b0, s: 1'b0, v: 1'b0, n: 1'b0, z: 1'b0, c: 1'b0};
    localparam bad_wr_t    BAD_WR_RESET    = '{en: 1'b0, idx: 5'h00, data: 8'h00};

    typedef enum logic [1:0] {
        BAD_ST_IDLE    = 2'b01,
        BAD_ST_WORD_HI = 2'b10
    } bad_state_t;

endpackage : bad_pkg

// >>> hdl/bad_adder8.sv
// Eight-bit add/subtract slice with carry, half-carry and overflow
module bad_adder8
    import bad_pkg::*;
(
    // Operands
    input  wire logic [7:0] i_a,
    input  wire logic [7:0] i_b,
    input  wire logic       i_cin,
    input  wire logic       i_sub,
    // Results
    output logic      [7:0] o_res,
    output logic            o_carry,
    output logic            o_half,
    output logic            o_ovf
);

    logic [7:0] b_eff;
    logic       c_eff;
    logic [8:0] full_sum;
    logic [4:0] nib_sum;

    // Subtract as a plus not-b plus not-borrow; carries invert back to borrows
    always_comb
    begin
        b_eff    = i_sub ? ~i_b : i_b;
        c_eff    = i_sub ? ~i_cin : i_cin;
        full_sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, c_eff};
        nib_sum  = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
        o_res    = full_sum[7:0];
        o_carry  = full_sum[8] ^ i_sub;
        o_half   = nib_sum[4] ^ i_sub;
        o_ovf    = (i_a[7] == b_eff[7]) && (full_sum[7] != i_a[7]);
    end

endmodule // bad_adder8

// >>> dv/bad_datapath_asserts.sv
// Port-level checks of the byte ALU datapath
module bad_datapath_asserts
    import bad_pkg::*;
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    // Observed ports
    input  wire logic       i_req_valid,
    input  wire bad_req_t   i_req,
    input  wire bad_wr_t    o_wr,
    input  wire bad_flags_t o_flags,
    input  wire logic       o_busy,
    input  wire logic       o_done
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    logic       tk;
    logic       wd;
    logic       c_q;
    logic [7:0] d_q;
    logic [7:0] s_q;
    bad_op_t    op;

    assign op = i_req.op;
    assign tk = i_req_valid && !o_busy && !i_sys_rst && op != BAD_OP_NOP;
    assign wd = op inside {BAD_OP_WORD_IMMEDIATE_INCREASE, BAD_OP_WORD_IMMEDIATE_DECREASE};

    // Operands one cycle back, for results seen after the taking edge
    always_ff @(posedge i_ref_clk)
    begin
        d_q <= i_req.dst_val;
        s_q <= i_req.src_val;
        c_q <= o_flags.c;
    end

    a_byte_one_cycle: assert property (tk && !wd |=> o_done && !o_busy)
        else $error("byte op not done after one cycle");
    a_done_cause: assert property (o_done |-> $past(tk) || $past(o_busy))
        else $error("done without a taken op");
    a_word_two_cycles: assert property (tk && wd |=> o_busy && o_wr.en && !o_done ##1 o_done && o_wr.en)
        else $error("word op timing wrong");
    a_word_pair_order: assert property (tk && wd |=> ##1 o_wr.idx == $past(i_req.dst_idx, 2) + BAD_PAIR_STEP)
        else $error("word high byte index wrong");
    a_word_dec_low: assert property (tk && op == BAD_OP_WORD_IMMEDIATE_DECREASE |=> o_wr.data == d_q - s_q)
        else $error("word decrease low byte wrong");
    a_sub_const: assert property (tk && op == BAD_OP_MINUS_CONSTANT |=> o_wr.data == d_q - s_q && o_flags.c == (d_q < s_q))
        else $error("constant subtract wrong");
    a_borrow_keeps_z: assert property (tk && op == BAD_OP_MINUS_WITH_BORROW && !o_flags.z |=> !o_flags.z)
        else $error("borrow subtract set zero flag");
    a_borrow_const: assert property (tk && op == BAD_OP_MINUS_CONST_WITH_BORROW |=> o_wr.data == d_q - s_q - c_q)
        else $error("constant borrow subtract wrong");
    a_and_result: assert property (tk && op == BAD_OP_MASK_WITH_CONSTANT |=> o_wr.data == (d_q & s_q) && !o_flags.v)
        else $error("and result wrong");
    a_or_result: assert property (tk && op == BAD_OP_MERGE_WITH_CONSTANT |=> o_wr.data == (d_q | s_q))
        else $error("or result wrong");
    a_set_bits: assert property (tk && op == BAD_OP_SET_MASK_BITS |=> o_wr.en && o_wr.data == (d_q | s_q))
        else $error("set bits wrong");
    a_clear_bits: assert property (tk && op == BAD_OP_CLEAR_MASK_BITS |=> o_wr.data == (d_q & (BAD_BYTE_ONES - s_q)))
        else $error("clear bits wrong");
    a_test_no_write: assert property (tk && op == BAD_OP_ZERO_SIGN_CHECK |=> o_done && !o_wr.en && o_flags.n == d_q[7])
        else $error("test op wrong");
    a_invert_carry: assert property (tk && op == BAD_OP_BITWISE_INVERT |=> o_flags.c && o_wr.data == ~d_q)
        else $error("invert wrong");

    c_word: cover property (tk && wd);
    c_refused: cover property (i_req_valid && o_busy);
    c_test: cover property (tk && op == BAD_OP_ZERO_SIGN_CHECK);
endmodule // bad_datapath_asserts

bind bad_datapath bad_datapath_asserts i_bad_datapath_asserts (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_wr(o_wr), .o_flags(o_flags), .o_busy(o_busy), .o_done(o_done));

// >>> dv/bad_regfile_model.sv
// Register file and decoder stand-in feeding the datapath
module bad_regfile_model
    import bad_pkg::*;
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    // Instruction fields and write-back
    input  wire bad_op_t    i_op,
    input  wire logic [4:0] i_dst,
    input  wire logic [4:0] i_src,
    input  wire logic [7:0] i_imm,
    input  wire logic       i_use_imm,
    input  wire bad_wr_t    i_wr,
    // Request to the datapath
    output bad_req_t        o_req
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [32];

    // Bypass the write in flight so back-to-back ops see fresh operands
    function automatic logic [7:0] rd(input logic [4:0] a);
        return (i_wr.en && i_wr.idx == a) ? i_wr.data : mem[a];
    endfunction

    always_comb
    begin
        o_req.op      = i_op;
        o_req.dst_idx = i_dst;
        o_req.dst_val = rd(i_dst);
        o_req.src_val = i_use_imm ? i_imm : rd(i_src);
        o_req.hi_val  = rd(i_dst + BAD_PAIR_STEP);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            for (int k = 0; k < 32; k++)
                mem[k] <= 8'(k * 29 + 7);
        end
        else if (i_wr.en)
            mem[i_wr.idx] <= i_wr.data;
    end
endmodule // bad_regfile_model

// >>> dv/tb_bad_datapath.sv
// Self-checking bench for the byte ALU datapath
module tb_bad_datapath
    import bad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst, vld, c_ui, busy, done, hp, e_done, e_busy;
    logic        on = 1'b0;
    logic [4:0]  c_dst, c_src, c_last;
    logic [7:0]  c_imm, ph;
    logic [31:0] lf = 32'hFB358870;
    int          err_count = 0;
    int          n_compared = 0;
    int          m [32];
    bad_op_t     c_op;
    bad_req_t    req;
    bad_wr_t     wr, e_wr;
    bad_flags_t  flags, e_flags, pf;

    bad_datapath i_bad_datapath (.i_ref_clk(clk), .i_sys_rst(rst), .i_req_valid(vld), .i_req(req),
        .o_wr(wr), .o_flags(flags), .o_busy(busy), .o_done(done));
    bad_regfile_model i_bad_regfile_model (.i_ref_clk(clk), .i_sys_rst(rst), .i_op(c_op), .i_dst(c_dst),
        .i_src(c_src), .i_imm(c_imm), .i_use_imm(c_ui), .i_wr(wr), .o_req(req));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        repeat (32) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reference model, one step per taking edge
    task automatic model_op();
        int         d, s, h, r, ci;
        logic       z;
        logic       wd;
        bad_flags_t f;
        d = m[c_dst];
        s = c_ui ? c_imm : m[c_src];
        h = m[c_dst + 5'h01];
        f = e_flags;
        ci = f.c;
        z = 1'b1;
        wd = c_op inside {BAD_OP_WORD_IMMEDIATE_INCREASE, BAD_OP_WORD_IMMEDIATE_DECREASE};
        f.v = 1'b0;
        case (c_op)
            BAD_OP_ADD_REGISTERS, BAD_OP_ADD_WITH_CARRY:
            begin
                if (c_op == BAD_OP_ADD_REGISTERS)
                    ci = 0;
                r = d + s + ci;
                f.c = r[8];
                f.h = d % 16 + s % 16 + ci > 15;
                f.v = d[7] == s[7] && r[7] != d[7];
            end
            BAD_OP_MINUS_REGISTER, BAD_OP_MINUS_CONSTANT, BAD_OP_MINUS_WITH_BORROW, BAD_OP_MINUS_CONST_WITH_BORROW:
            begin
                if (c_op inside {BAD_OP_MINUS_REGISTER, BAD_OP_MINUS_CONSTANT})
                    ci = 0;
                else
                    z = f.z;
                r = d - s - ci;
                f.c = d < s + ci;
                f.h = d % 16 < s % 16 + ci;
                f.v = d[7] != s[7] && r[7] != d[7];
            end
            BAD_OP_AND_REGISTERS, BAD_OP_MASK_WITH_CONSTANT: r = d & s;
            BAD_OP_OR_REGISTERS, BAD_OP_MERGE_WITH_CONSTANT, BAD_OP_SET_MASK_BITS: r = d | s;
            BAD_OP_EXCLUSIVE_OR_REGISTERS: r = d ^ s;
            BAD_OP_CLEAR_MASK_BITS: r = d & (255 - s);
            BAD_OP_BITWISE_INVERT: r = 255 - d;
            BAD_OP_ARITHMETIC_MINUS_SELF: r = (256 - d) % 256;
            BAD_OP_PLUS_ONE: r = (d + 1) % 256;
            BAD_OP_MINUS_ONE: r = (d + 255) % 256;
            BAD_OP_WORD_IMMEDIATE_INCREASE: r = h * 256 + d + s;
            BAD_OP_WORD_IMMEDIATE_DECREASE: r = h * 256 + d - s;
            default: r = d;
        endcase
        case (c_op)
            BAD_OP_BITWISE_INVERT: f.c = 1'b1;
            BAD_OP_ARITHMETIC_MINUS_SELF: {f.c, f.v, f.h} = {r != 0, r == 128, d % 16 != 0};
            BAD_OP_PLUS_ONE: f.v = r == 128;
            BAD_OP_MINUS_ONE: f.v = r == 127;
            default: ;
        endcase
        if (wd)
        begin
            f.c = r > 65535 || r < 0;
            r = r & 65535;
            f.v = c_op == BAD_OP_WORD_IMMEDIATE_INCREASE ? !h[7] && r[15] : h[7] && !r[15];
            f.n = r[15];
            f.z = r == 0;
            f.s = f.n ^ f.v;
            pf = f;
            ph = r[15:8];
            hp = 1'b1;
            c_last = c_dst;
            m[c_dst] = r & 255;
            m[c_dst + 5'h01] = r / 256;
            e_wr = '{en: 1'b1, idx: c_dst, data: 8'(r)};
            e_busy = 1'b1;
        end
        else
        begin
            r = r & 255;
            f.n = r[7];
            f.z = z && r == 0;
            f.s = f.n ^ f.v;
            e_flags = f;
            e_done = 1'b1;
            if (c_op != BAD_OP_ZERO_SIGN_CHECK)
            begin
                m[c_dst] = r;
                e_wr = '{en: 1'b1, idx: c_dst, data: 8'(r)};
            end
        end
    endtask

    always @(posedge clk)
    begin
        e_wr.en = 1'b0;
        e_done = 1'b0;
        e_busy = 1'b0;
        if (rst)
        begin
            on = 1'b1;
            hp = 1'b0;
            e_wr = BAD_WR_RESET;
            e_flags = BAD_FLAGS_RESET;
            for (int k = 0; k < 32; k++)
                m[k] = (k * 29 + 7) % 256;
        end
        else if (hp)
        begin
            // Requests in this cycle are refused by the design
            hp = 1'b0;
            e_wr = '{en: 1'b1, idx: c_last + 5'h01, data: ph};
            e_flags = pf;
            e_done = 1'b1;
        end
        else if (vld && c_op != BAD_OP_NOP)
            model_op();
    end

    always @(negedge clk)
    begin
        if (on)
        begin
            chk("write", 16'(wr), 16'(e_wr));
            chk("flags", 16'(flags), 16'(e_flags));
            chk("done", 16'(done), 16'(e_done));
            chk("busy", 16'(busy), 16'(e_busy));
        end
    end

    task automatic stim(input int i);
        logic [31:0] x;
        bad_op_t     o;
        logic        w;
        x = rnd();
        o = bad_op_t'(5'(i < 21 ? i : x[4:0] % 21));
        w = o inside {BAD_OP_WORD_IMMEDIATE_INCREASE, BAD_OP_WORD_IMMEDIATE_DECREASE};
        vld <= i < 21 || x[9:8] != 2'h0;
        c_op <= o;
        c_dst <= x[14:10];
        c_src <= x[19:15];
        c_imm <= w ? {2'h0, x[25:20]} : x[31:24];
        c_ui <= w || o inside {BAD_OP_MINUS_CONSTANT, BAD_OP_MINUS_CONST_WITH_BORROW, BAD_OP_MASK_WITH_CONSTANT,
                               BAD_OP_MERGE_WITH_CONSTANT, BAD_OP_SET_MASK_BITS, BAD_OP_CLEAR_MASK_BITS};
    endtask

    initial
    begin
        rst = 1'b1;
        vld = 1'b0;
        c_op = BAD_OP_NOP;
        c_dst = 5'h00;
        c_src = 5'h00;
        c_imm = 8'h00;
        c_ui = 1'b0;
        repeat (2) @(posedge clk);
        // Every op code in turn (codes 0x04 and 0x09 come while busy after a word op and are refused), then random back-to-back traffic with a reset mid-run
        for (int i = 0; i < 900; i++)
        begin
            rst <= i inside {[400:401]};
            stim(i);
            @(posedge clk);
        end
        @(negedge clk);
        summarize();
    end
endmodule // tb_bad_datapath
